/* File: inc/fps_pkg.sv */
// package for the flyback pwm fault sequencer: states, timing counts, carriers
package fps_pkg;
  // oscillator-cycle counts for the cycle-counted timers
  localparam int unsigned STARTUP_CYCLES = 2048;
  localparam int unsigned HICCUP_CYCLES = 32768;
  localparam int unsigned OVERLOAD_CYCLES = 4096;
  localparam int unsigned LINE_UV_CYCLES = 4096;
  // printed times, for reference against the counts (ms)
  localparam real STARTUP_TIME_MS = 31.0;
  localparam real HICCUP_TIME_MS = 504.0;
  localparam real OVERLOAD_TIME_MS = 63.0;
  localparam real LINE_UV_TIME_MS = 63.0;
  // maximum duty in percent of the switching period
  localparam int unsigned MAX_DUTY_PCT = 77;
  localparam int unsigned TMR_W = 16;
  localparam int unsigned PER_W = 16;
  // soft-start limit steps: first half of startup uses step 1, then step 2
  localparam logic [1:0] LIMIT_STEP1 = 2'h1;
  localparam logic [1:0] LIMIT_STEP2 = 2'h2;
  localparam logic [1:0] LIMIT_FULL = 2'h3;

  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_RUN     = 5'h02,
    ST_BURST   = 5'h04,
    ST_HICCUP  = 5'h08,
    ST_LATCHED = 5'h10
  } fps_state_t;

  // comparator results, all asynchronous to mclk
  typedef struct packed {
    logic fb_below_burst_entry;
    logic fb_above_burst_exit;
    logic fb_above_overload;
    logic line_above_uv_rising;
    logic line_below_uv_falling;
    logic cs_at_command;
    logic cs_at_short_winding;
    logic supply_at_start;
    logic supply_below_hv_reenable;
    logic supply_below_lockout;
    logic supply_at_ovp_latch;
    logic osc_tick;
  } fps_sense_t;

  typedef struct packed {
    logic switch_on;
    logic hv_source_on;
    logic [1:0] current_limit_step;
    logic short_circuit_guard_en;
    logic latched_off;
    logic hiccup_active;
    logic burst_active;
  } fps_ctrl_t;
endpackage

/* File: verilog/fps_sequencer.sv */
// flyback pwm fault sequencer: switching gate, startup, burst, brown-out, hiccup, latch-off
module fps_sequencer (
  input wire logic mclk,
  input wire logic resetn,
  input wire fps_pkg::fps_sense_t sense,
  output fps_pkg::fps_ctrl_t ctrl,
  output fps_pkg::fps_state_t state
);
  import fps_pkg::*;

  // two-flop synchronisers on all comparator inputs
  fps_sense_t sync1_q, sync2_q, sense_s;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sense;
      sync2_q <= sync1_q;
    end
  end
  assign sense_s = sync2_q;

  // oscillator tick edge: one-cycle enable per switching period
  logic tick_prev_q;
  logic tick;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) tick_prev_q <= 1'b0;
    else tick_prev_q <= sense_s.osc_tick;
  end
  assign tick = sense_s.osc_tick & ~tick_prev_q;

  function automatic logic expired(input logic [TMR_W-1:0] cnt, input int unsigned lim);
    expired = (cnt >= TMR_W'(lim - 1));
  endfunction

  // measured switching period in mclk cycles, used for the duty ceiling
  logic [PER_W-1:0] per_cnt_q, period_q, on_cnt_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      per_cnt_q <= '0;
      period_q <= '1;
    end else if (tick) begin
      // a saturated count keeps the ceiling wide instead of wrapping to zero
      period_q <= (per_cnt_q == '1) ? per_cnt_q : per_cnt_q + PER_W'(1);
      per_cnt_q <= '0;
    end else if (per_cnt_q != '1) begin
      per_cnt_q <= per_cnt_q + PER_W'(1);
    end
  end
  logic [PER_W+6:0] duty_limit;
  assign duty_limit = 23'(({7'h00, period_q} * 23'(MAX_DUTY_PCT)) / 23'd100);

  fps_state_t state_q, state_d;
  logic [TMR_W-1:0] st_tmr_q, hic_tmr_q, ol_tmr_q, uv_tmr_q;
  logic startup_q, ol_run_q, uv_run_q, line_ok_q;
  logic latch_req, ol_trip, uv_trip;

  assign latch_req = sense_s.cs_at_short_winding | sense_s.supply_at_ovp_latch;
  assign ol_trip = ol_run_q & tick & expired(ol_tmr_q, OVERLOAD_CYCLES)
                   & sense_s.fb_above_overload;
  assign uv_trip = uv_run_q & tick & expired(uv_tmr_q, LINE_UV_CYCLES);

  // brown-in / brown-out qualifier
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) line_ok_q <= 1'b0;
    else if (sense_s.line_above_uv_rising) line_ok_q <= 1'b1;
    else if (uv_trip) line_ok_q <= 1'b0;
  end

  // line uv delay timer, armed while line sits below falling threshold
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      uv_run_q <= 1'b0;
      uv_tmr_q <= '0;
    end else if (!sense_s.line_below_uv_falling || !line_ok_q) begin
      uv_run_q <= 1'b0;
      uv_tmr_q <= '0;
    end else if (!uv_run_q) begin
      uv_run_q <= 1'b1;
    end else if (tick && !expired(uv_tmr_q, LINE_UV_CYCLES)) begin
      uv_tmr_q <= uv_tmr_q + TMR_W'(1);
    end
  end

  // overload fault timer; a dip below threshold restarts it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ol_run_q <= 1'b0;
      ol_tmr_q <= '0;
    end else if (state_q != ST_RUN && state_q != ST_BURST) begin
      ol_run_q <= 1'b0;
      ol_tmr_q <= '0;
    end else if (!ol_run_q) begin
      ol_run_q <= sense_s.fb_above_overload;
      ol_tmr_q <= '0;
    end else if (ol_trip || !sense_s.fb_above_overload) begin
      ol_run_q <= 1'b0;
      ol_tmr_q <= '0;
    end else if (tick) begin
      ol_tmr_q <= ol_tmr_q + TMR_W'(1);
    end
  end

  logic start_ok;
  assign start_ok = sense_s.supply_at_start & line_ok_q;

  // main sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: if (start_ok) state_d = ST_RUN;
      ST_RUN: begin
        if (uv_trip || sense_s.supply_below_lockout) state_d = ST_OFF;
        else if (ol_trip) state_d = ST_HICCUP;
        else if (sense_s.fb_below_burst_entry) state_d = ST_BURST;
      end
      ST_BURST: begin
        if (uv_trip || sense_s.supply_below_lockout) state_d = ST_OFF;
        else if (ol_trip) state_d = ST_HICCUP;
        else if (sense_s.fb_above_burst_exit) state_d = ST_RUN;
      end
      ST_HICCUP: if (tick && expired(hic_tmr_q, HICCUP_CYCLES)) state_d = ST_OFF;
      ST_LATCHED: if (sense_s.supply_below_lockout) state_d = ST_OFF;
      default: state_d = ST_OFF;
    endcase
    // a standing latch request keeps the latch, even when lockout is also seen
    if (latch_req) state_d = ST_LATCHED;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) state_q <= ST_OFF;
    else state_q <= state_d;
  end

  // hiccup timer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) hic_tmr_q <= '0;
    else if (state_q != ST_HICCUP) hic_tmr_q <= '0;
    else if (tick && !expired(hic_tmr_q, HICCUP_CYCLES)) hic_tmr_q <= hic_tmr_q + TMR_W'(1);
  end

  // startup timer; its running window is also the short-circuit blanking
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      startup_q <= 1'b0;
      st_tmr_q <= '0;
    end else if (state_q == ST_OFF && state_d == ST_RUN) begin
      startup_q <= 1'b1;
      st_tmr_q <= '0;
    end else if (state_q == ST_OFF || state_q == ST_HICCUP || state_q == ST_LATCHED) begin
      startup_q <= 1'b0;
      st_tmr_q <= '0;
    end else if (startup_q && tick) begin
      if (expired(st_tmr_q, STARTUP_CYCLES)) startup_q <= 1'b0;
      else st_tmr_q <= st_tmr_q + TMR_W'(1);
    end
  end

  // hv charging source: off once switching, on again below re-enable level
  logic hv_on_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) hv_on_q <= 1'b1;
    else if (state_q == ST_RUN || state_q == ST_BURST) begin
      if (sense_s.supply_below_hv_reenable) hv_on_q <= 1'b1;
      else if (state_q == ST_RUN) hv_on_q <= 1'b0;
    end else hv_on_q <= 1'b1;
  end

  // switching cycle: set on tick, reset on current sense, duty limit or fault
  logic sw_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sw_q <= 1'b0;
      on_cnt_q <= '0;
    end else if (state_d != ST_RUN || state_q != ST_RUN) begin
      sw_q <= 1'b0;
      on_cnt_q <= '0;
    end else if (tick) begin
      sw_q <= 1'b1;
      on_cnt_q <= '0;
    end else if (sw_q) begin
      on_cnt_q <= on_cnt_q + PER_W'(1);
      if (sense_s.cs_at_command) sw_q <= 1'b0;
      else if ({7'h00, on_cnt_q} + 23'd1 >= duty_limit) sw_q <= 1'b0;
    end
  end

  // limit step follows the startup timer halves
  logic [1:0] limit_step;
  always_comb begin
    if (!startup_q) limit_step = LIMIT_FULL;
    else if (st_tmr_q < TMR_W'(STARTUP_CYCLES / 2)) limit_step = LIMIT_STEP1;
    else limit_step = LIMIT_STEP2;
  end

  logic [1:0] limit_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) limit_q <= LIMIT_STEP1;
    else limit_q <= limit_step;
  end

  // one process drives the whole carrier, so no field has two kinds of driver
  always_comb begin
    ctrl = '0;
    ctrl.switch_on = sw_q;
    ctrl.hv_source_on = hv_on_q;
    ctrl.current_limit_step = limit_q;
    ctrl.short_circuit_guard_en = ~startup_q;
    ctrl.latched_off = (state_q == ST_LATCHED);
    ctrl.hiccup_active = (state_q == ST_HICCUP);
    ctrl.burst_active = (state_q == ST_BURST);
  end
  assign state = state_q;

  // assertions: latch-off
  a_latch_wins: assert property (@(posedge mclk) disable iff (!resetn)
    latch_req |=> state_q == ST_LATCHED)
    else $error("latch request not honoured");
  a_latch_hold: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_LATCHED && !sense_s.supply_below_lockout |=> state_q == ST_LATCHED)
    else $error("latch released early");
  a_lock_release: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_LATCHED && sense_s.supply_below_lockout && !latch_req |=> state_q == ST_OFF)
    else $error("latch not released at lockout");
  a_switch_off_latch: assert property (@(posedge mclk) disable iff (!resetn)
    latch_req |=> !sw_q)
    else $error("switch on after short winding");
  a_latched_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_LATCHED |-> !sw_q)
    else $error("switching while latched");

  // assertions: switching cycle
  a_cs_turnoff: assert property (@(posedge mclk) disable iff (!resetn)
    sw_q && sense_s.cs_at_command && !tick |=> !sw_q)
    else $error("switch ignored current sense");
  a_tick_turnon: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_RUN && state_d == ST_RUN && tick |=> sw_q)
    else $error("no turn-on at tick");
  a_duty_limit: assert property (@(posedge mclk) disable iff (!resetn)
    sw_q |-> {7'h00, on_cnt_q} < duty_limit)
    else $error("duty ceiling exceeded");
  a_off_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_OFF |-> !sw_q)
    else $error("switching while off");

  // assertions: burst
  a_burst_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_BURST |-> !sw_q)
    else $error("switching in burst");
  a_burst_entry: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_RUN && sense_s.fb_below_burst_entry && !latch_req && !uv_trip && !ol_trip
    && !sense_s.supply_below_lockout |=> state_q == ST_BURST)
    else $error("burst not entered");
  a_burst_exit: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_BURST && sense_s.fb_above_burst_exit && !latch_req && !uv_trip && !ol_trip
    && !sense_s.supply_below_lockout |=> state_q == ST_RUN)
    else $error("burst not left");

  // assertions: start-up and hv source
  a_start_run: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_OFF && start_ok && !latch_req |=> state_q == ST_RUN && startup_q)
    else $error("start not taken");
  a_hv_off_run: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_RUN && !sense_s.supply_below_hv_reenable |=> !ctrl.hv_source_on)
    else $error("hv source left on");
  a_hv_reenable: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == ST_RUN || state_q == ST_BURST) && sense_s.supply_below_hv_reenable
    |=> ctrl.hv_source_on)
    else $error("hv source not re-enabled");
  a_hv_idle: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_OFF || state_q == ST_HICCUP || state_q == ST_LATCHED |=> ctrl.hv_source_on)
    else $error("hv source off while idle");
  a_limit_first: assert property (@(posedge mclk) disable iff (!resetn)
    startup_q && st_tmr_q < TMR_W'(STARTUP_CYCLES / 2) |=> ctrl.current_limit_step == LIMIT_STEP1)
    else $error("first limit step missing");
  a_limit_full: assert property (@(posedge mclk) disable iff (!resetn)
    !startup_q |=> ctrl.current_limit_step == LIMIT_FULL)
    else $error("limit not full after startup");
  a_blank_startup: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(startup_q) |-> !ctrl.short_circuit_guard_en && st_tmr_q == '0)
    else $error("guard not blanked");
  a_startup_len: assert property (@(posedge mclk) disable iff (!resetn)
    startup_q && (state_q == ST_RUN || state_q == ST_BURST)
    && !expired(st_tmr_q, STARTUP_CYCLES) |=> startup_q)
    else $error("startup ended early");

  // assertions: line undervoltage
  a_no_low_start: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_OFF && !line_ok_q |=> state_q != ST_RUN)
    else $error("started on low line");
  a_line_ok_set: assert property (@(posedge mclk) disable iff (!resetn)
    sense_s.line_above_uv_rising |=> line_ok_q)
    else $error("brown-in not remembered");
  a_uv_stop: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == ST_RUN || state_q == ST_BURST) && uv_trip && !latch_req |=> state_q == ST_OFF)
    else $error("brown-out did not stop");
  a_uv_count: assert property (@(posedge mclk) disable iff (!resetn)
    uv_trip |-> uv_tmr_q == TMR_W'(LINE_UV_CYCLES - 1))
    else $error("line uv delay length wrong");

  // assertions: overload and hiccup
  a_ol_start: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == ST_RUN || state_q == ST_BURST) && !ol_run_q && sense_s.fb_above_overload
    |=> ol_run_q)
    else $error("overload timer not started");
  a_ol_restart: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == ST_RUN || state_q == ST_BURST) && ol_run_q && !sense_s.fb_above_overload
    |=> !ol_run_q && ol_tmr_q == '0)
    else $error("overload timer kept running");
  a_ol_trip: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == ST_RUN || state_q == ST_BURST) && ol_trip && !latch_req && !uv_trip
    && !sense_s.supply_below_lockout |=> state_q == ST_HICCUP)
    else $error("overload did not stop switching");
  a_hiccup_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_HICCUP |-> !sw_q && !ol_run_q)
    else $error("switching in hiccup");
  a_hiccup_len: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_HICCUP && !latch_req && !expired(hic_tmr_q, HICCUP_CYCLES)
    |=> state_q == ST_HICCUP)
    else $error("hiccup ended early");
  a_hiccup_restart: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_HICCUP && tick && expired(hic_tmr_q, HICCUP_CYCLES) && !latch_req
    |=> state_q == ST_OFF)
    else $error("no restart after hiccup");

  c_burst: cover property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_BURST ##1 state_q == ST_RUN);
  c_hiccup: cover property (@(posedge mclk) disable iff (!resetn) state_q == ST_HICCUP);
  c_latch: cover property (@(posedge mclk) disable iff (!resetn) $rose(ctrl.latched_off));
  c_uv_stop: cover property (@(posedge mclk) disable iff (!resetn) uv_trip);
  c_restart: cover property (@(posedge mclk) disable iff (!resetn)
    state_q == ST_HICCUP ##1 state_q == ST_OFF);
endmodule // fps_sequencer

/* File: bench/fps_analog_model.sv */
// partner model: oscillator tick source and current-sense comparator
module fps_analog_model (
  input wire logic mclk,
  input wire logic switch_on,
  input var int period,
  input var int cs_delay,
  output logic osc_tick,
  output logic cs_at_command
);
  timeunit 1ns;
  timeprecision 1ps;
  int phase = 0;
  int on_cnt = 0;
  initial osc_tick = 1'b0;
  initial cs_at_command = 1'b0;
  // a zero delay models a current that never reaches the command level
  always @(negedge mclk) begin
    phase <= (phase + 1 >= period) ? 0 : phase + 1;
    osc_tick <= (phase < period / 2);
    on_cnt <= switch_on ? on_cnt + 1 : 0;
    cs_at_command <= switch_on && cs_delay != 0 && on_cnt + 1 >= cs_delay;
  end
endmodule // fps_analog_model

/* File: bench/fps_sequencer_tb.sv */
// self-checking bench for the flyback pwm fault sequencer
module fps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fps_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  fps_sense_t s_tb = '0;
  fps_sense_t sense;
  fps_ctrl_t ctrl;
  fps_state_t state;
  logic tick;
  logic cs;
  int per = 20;
  int cs_dly = 4;
  int num_errors = 0;
  int checks = 0;
  int rises = 0;
  int on_len = 0;
  int on_max = 0;
  int cs_age = 0;
  logic sw_prev = 1'b0;
  logic [31:0] rng = 32'h0001376b;

  always #5 mclk = ~mclk;
  always_comb begin
    sense = s_tb;
    sense.osc_tick = tick;
    sense.cs_at_command = cs;
  end

  fps_sequencer u_fps_sequencer (.mclk(mclk), .resetn(resetn), .sense(sense),
    .ctrl(ctrl), .state(state));
  fps_analog_model u_fps_analog_model (.mclk(mclk), .switch_on(ctrl.switch_on),
    .period(per), .cs_delay(cs_dly), .osc_tick(tick), .cs_at_command(cs));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk_val(string nm, logic [1:0] exp, logic [1:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic chk_state(fps_state_t exp);
    checks++;
    if (state !== exp) begin
      num_errors++;
      $display("BAD state expected %0h seen %0h", exp, state);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic ticks(int n);
    repeat (n * per) @(negedge mclk);
  endtask

  // brown-in is remembered, so a short pulse of the rising comparator is enough
  task automatic go_run();
    s_tb.line_above_uv_rising = 1'b1;
    cyc(5);
    s_tb.line_above_uv_rising = 1'b0;
    cyc(2);
  endtask

  task automatic lockout_cycle();
    s_tb.supply_at_start = 1'b0;
    s_tb.supply_below_lockout = 1'b1;
    cyc(5);
    chk_state(ST_OFF);
    s_tb.supply_below_lockout = 1'b0;
    s_tb.supply_at_start = 1'b1;
    cyc(5);
  endtask

  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // switch must drop within 4 cycles after the comparator trips, and never stay on for more than 17 cycles
  always @(negedge mclk) begin
    if (ctrl.switch_on && !sw_prev) rises++;
    on_len = ctrl.switch_on ? on_len + 1 : 0;
    if (on_len > on_max) on_max = on_len;
    cs_age = (cs && ctrl.switch_on) ? cs_age + 1 : 0;
    if (cs_age > 4) chk_val("off_after_cs", 2'h0, 2'h1);
    if (on_len > 17) chk_val("duty_ceiling", 2'h0, 2'h1);
    sw_prev = ctrl.switch_on;
  end

  initial begin
    // the tests need about 88k cycles, most of them in the hiccup wait
    repeat (95000) @(posedge mclk);
    num_errors++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    cyc(12);
    chk_state(ST_OFF);
    chk_val("hv_on", 2'h1, {1'b0, ctrl.hv_source_on});
    chk_val("guard_en", 2'h1, {1'b0, ctrl.short_circuit_guard_en});
    resetn = 1'b1;
    per = 2;
    s_tb.supply_at_start = 1'b1;
    cyc(40);
    chk_state(ST_OFF);
    go_run();
    chk_state(ST_RUN);
    chk_val("guard_en", 2'h0, {1'b0, ctrl.short_circuit_guard_en});
    chk_val("hv_on", 2'h0, {1'b0, ctrl.hv_source_on});
    chk_val("limit", LIMIT_STEP1, ctrl.current_limit_step);
    ticks(1100);
    chk_val("limit", LIMIT_STEP2, ctrl.current_limit_step);
    chk_val("guard_en", 2'h0, {1'b0, ctrl.short_circuit_guard_en});
    ticks(1000);
    chk_val("limit", LIMIT_FULL, ctrl.current_limit_step);
    chk_val("guard_en", 2'h1, {1'b0, ctrl.short_circuit_guard_en});
    $display("startup test done");
    per = 20;
    ticks(2);
    rises = 0;
    for (int i = 0; i < 40; i++) begin
      cs_dly = 2 + int'(xs() % 8);
      ticks(1);
    end
    chk_val("tick_starts", 2'h1, {1'b0, rises >= 38});
    cs_dly = 0;
    on_max = 0;
    ticks(10);
    chk_val("ceiling_hit", 2'h1, {1'b0, on_max == per * MAX_DUTY_PCT / 100});
    cs_dly = 4;
    s_tb.supply_below_hv_reenable = 1'b1;
    cyc(5);
    chk_val("hv_on", 2'h1, {1'b0, ctrl.hv_source_on});
    s_tb.supply_below_hv_reenable = 1'b0;
    $display("switching test done");
    s_tb.fb_below_burst_entry = 1'b1;
    cyc(5);
    chk_state(ST_BURST);
    rises = 0;
    ticks(10);
    chk_val("burst_starts", 2'h0, {1'b0, rises != 0});
    s_tb.fb_below_burst_entry = 1'b0;
    cyc(5);
    chk_state(ST_BURST);
    s_tb.fb_above_burst_exit = 1'b1;
    cyc(5);
    chk_state(ST_RUN);
    rises = 0;
    ticks(3);
    chk_val("resume", 2'h1, {1'b0, rises >= 2});
    s_tb.fb_above_burst_exit = 1'b0;
    $display("burst test done");
    per = 2;
    s_tb.fb_above_overload = 1'b1;
    ticks(4000);
    chk_state(ST_RUN);
    ticks(200);
    chk_state(ST_HICCUP);
    chk_val("hiccup_off", 2'h2, {ctrl.hiccup_active, ctrl.switch_on});
    s_tb.fb_above_overload = 1'b0;
    // about 100 ticks of the hiccup are already gone here
    ticks(32500);
    chk_state(ST_HICCUP);
    ticks(300);
    chk_state(ST_RUN);
    chk_val("guard_en", 2'h0, {1'b0, ctrl.short_circuit_guard_en});
    chk_val("limit", LIMIT_STEP1, ctrl.current_limit_step);
    s_tb.supply_at_ovp_latch = 1'b1;
    cyc(5);
    chk_state(ST_LATCHED);
    s_tb.supply_at_ovp_latch = 1'b0;
    s_tb.fb_above_burst_exit = 1'b1;
    cyc(20);
    chk_state(ST_LATCHED);
    s_tb.fb_above_burst_exit = 1'b0;
    lockout_cycle();
    chk_state(ST_RUN);
    $display("overload test done");
    per = 20;
    for (int i = 0; i < 60 && !ctrl.switch_on; i++) cyc(1);
    s_tb.cs_at_short_winding = 1'b1;
    cyc(4);
    chk_val("latch_off", 2'h2, {ctrl.latched_off, ctrl.switch_on});
    s_tb.cs_at_short_winding = 1'b0;
    cyc(20);
    chk_state(ST_LATCHED);
    lockout_cycle();
    $display("latch test done");
    per = 2;
    s_tb.line_below_uv_falling = 1'b1;
    ticks(4000);
    chk_state(ST_RUN);
    ticks(200);
    chk_state(ST_OFF);
    s_tb.line_below_uv_falling = 1'b0;
    cyc(20);
    chk_state(ST_OFF);
    go_run();
    chk_state(ST_RUN);
    $display("brown-out test done");
    conclude();
  end
endmodule // fps_sequencer_tb
